// ===== include/via_pkg.sv
// Purpose: Shared constants and types of the vectored interrupt acceptor
// Assumes: One 40 MHz clock; instruction boundaries are flagged by the sequencer
// Notes:   Source index 9 is the highest priority, index 0 the lowest
`default_nettype none
package via_pkg;
	localparam int N_SRC       = 10;
	localparam int PC_W        = 14;
	localparam int DATA_W      = 16;
	localparam int ADDR_W      = 2;
	localparam int ASTK_DEPTH  = 8;
	localparam int SP_W        = 3;
	localparam int WR_W        = 4;
	localparam int BANK_W      = 4;
	localparam int RP_W        = 7;
	localparam int PSW_W       = 5;
	localparam int SYS_W       = WR_W + BANK_W + RP_W + PSW_W;
	localparam int ISK_LEVELS  = 2;
	localparam int DEPTH_W     = 2;
	localparam int VIDX_W      = 4;

	// Instruction time and the interrupt cycle length derived from it
	localparam int CLK_PERIOD_NS  = 25;
	localparam int INSTR_TIME_NS  = 2000;
	localparam int IRQ_CYCLES     = INSTR_TIME_NS / CLK_PERIOD_NS;
	localparam int CNT_W          = 7;

	// Vector of source i is i plus this base
	localparam logic [PC_W-1:0]  VEC_BASE  = 14'h0001;
	localparam logic [SP_W-1:0]  SP_RESET  = 3'h0;

	// Register indices on the plain register port
	localparam logic [ADDR_W-1:0] REG_REQ  = 2'h0;
	localparam logic [ADDR_W-1:0] REG_EN   = 2'h1;
	localparam logic [ADDR_W-1:0] REG_STAT = 2'h2;

	// Status register field positions
	localparam int STAT_GE        = 0;
	localparam int STAT_ARM       = 1;
	localparam int STAT_DEPTH_LSB = 2;
	localparam int STAT_SP_LSB    = 4;
	localparam int STAT_BUSY      = 7;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_DEC_SP,
		ST_PUSH_PC,
		ST_SAVE_SYS,
		ST_LOAD_VEC,
		ST_HOLD
	} via_state_e;
endpackage
`default_nettype wire

// ===== core/via_core.sv
// Purpose: Global enable, daisy-chain acceptance, interrupt cycle and return
// Assumes: Instruction class inputs are valid while instr_done is high
// Notes:   Calls are pushed by the sequencer elsewhere; this block owns the stacks
//
// Summary of operation
// - Global enable gates every acceptance
// - Enable-all takes effect after next instruction
// - Mask-all clears global enable at once
// - Acceptance clears global enable
// - Redundant enable-all or mask-all changes nothing
// - Reset, clock-stop, chip-enable reset clear enable
// - Peripheral event sets its request flag
// - Pending is request and enable, gated globally
// - Accepted source clears flag, outputs vector
// - Daisy chain, remote pin highest, group0 lowest
// - Disabled source neither accepted nor blocking
// - Deferring instructions postpone acceptance one instruction
// - Request during enable-all waits next instruction
// - Interrupt cycle: clear, decrement, push, save, vector
// - Pushed address is next address to run
// - Save window, bank, pointer, status word
// - Vector loaded into program counter last
// - Return reloads PC, restores, increments pointer
// - Subroutine exits skip system register restore
// - Vectors fixed from 000AH down to 0001H
// - After save clear system registers except window
// - Two saved levels, third discards oldest
`default_nettype none
module via_core
	import via_pkg::*;
(
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	input  wire logic                          ce_reset,
	input  wire logic [via_pkg::N_SRC-1:0]     src_req,
	input  wire logic                          instr_done,
	input  wire logic                          enable_all_instr,
	input  wire logic                          mask_all_instr,
	input  wire logic                          clock_stop_instr,
	input  wire logic                          instr_defer,
	input  wire logic                          irq_return_instr,
	input  wire logic                          subroutine_exit,
	input  wire logic                          skip_subroutine_exit,
	input  wire logic [via_pkg::PC_W-1:0]      pc_next,
	input  wire logic [via_pkg::WR_W-1:0]      window_in,
	input  wire logic [via_pkg::BANK_W-1:0]    bank_in,
	input  wire logic [via_pkg::RP_W-1:0]      gp_reg_pointer_in,
	input  wire logic [via_pkg::PSW_W-1:0]     status_word_reg_in,
	input  wire logic [via_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [via_pkg::DATA_W-1:0]    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [via_pkg::DATA_W-1:0]    reg_rdata,
	output logic                               global_irq_enable_ff,
	output logic                               irq_accept,
	output logic                               irq_cycle_busy,
	output logic                               pc_load,
	output logic      [via_pkg::PC_W-1:0]      pc_value,
	output logic                               sys_load,
	output logic      [via_pkg::WR_W-1:0]      window_out,
	output logic      [via_pkg::BANK_W-1:0]    bank_out,
	output logic      [via_pkg::RP_W-1:0]      gp_reg_pointer_out,
	output logic      [via_pkg::PSW_W-1:0]     status_word_reg_out
);
	import via_pkg::*;

	typedef struct packed {
		logic                                  ge;
		logic                                  armed;
		logic [N_SRC-1:0]                      req;
		logic [N_SRC-1:0]                      en;
		via_state_e                            state;
		logic [CNT_W-1:0]                      cnt;
		logic [SP_W-1:0]                       sp;
		logic [ASTK_DEPTH-1:0][PC_W-1:0]       astk;
		logic [DEPTH_W-1:0]                    depth;
		logic [ISK_LEVELS-1:0][SYS_W-1:0]      isk;
		logic [VIDX_W-1:0]                     vidx;
		logic [PC_W-1:0]                       pc_save;
		logic                                  accept;
		logic                                  busy;
		logic                                  pc_load;
		logic [PC_W-1:0]                       pc_value;
		logic                                  sys_load;
		logic [SYS_W-1:0]                      sys;
		logic [DATA_W-1:0]                     rdata;
	} via_state_s;

	via_state_s         q;
	via_state_s         next_q;
	logic [N_SRC-1:0]   pend;
	logic [N_SRC-1:0]   above;
	logic [N_SRC-1:0]   grant;
	logic               ge_eff;
	logic               ret_any;
	logic               take;
	logic [VIDX_W-1:0]  grant_idx;

	// Daisy chain: a pending source blocks everything below it
	genvar gi;
	generate
		for (gi = 0; gi < N_SRC; gi++) begin : g_chain
			assign pend[gi] = q.req[gi] & q.en[gi];
			if (gi == N_SRC - 1) begin : g_top
				assign above[gi] = 1'b0;
			end else begin : g_low
				assign above[gi] = above[gi+1] | pend[gi+1];
			end
			assign grant[gi] = take & pend[gi] & ~above[gi];
		end
	endgenerate

	// Armed enable-all lands at this boundary, so this boundary already counts
	assign ge_eff  = q.ge | q.armed;
	assign ret_any = irq_return_instr | subroutine_exit | skip_subroutine_exit;
	// Returns finishing now touch the stacks; acceptance waits a boundary
	assign take    = instr_done & (q.state == ST_RUN) & ~instr_defer
	                 & ~mask_all_instr & ~clock_stop_instr & ~ret_any & ~ce_reset
	                 & ge_eff & (|pend);

	always_comb begin
		grant_idx = '0;
		for (int i = 0; i < N_SRC; i++) begin
			if (grant[i]) begin
				grant_idx = VIDX_W'(i);
			end
		end
	end

	always_comb begin
		next_q          = q;
		next_q.accept   = 1'b0;
		next_q.pc_load  = 1'b0;
		next_q.sys_load = 1'b0;
		next_q.rdata    = '0;

		// Global enable flip-flop
		if (instr_done && q.armed) begin
			next_q.ge    = 1'b1;
			next_q.armed = 1'b0;
		end
		if (instr_done && enable_all_instr && !q.ge && !q.armed) begin
			next_q.armed = 1'b1;
		end
		if (mask_all_instr) begin
			next_q.ge    = 1'b0;
			next_q.armed = 1'b0;
		end
		if (take) begin
			next_q.ge    = 1'b0;
			next_q.armed = 1'b0;
		end
		if (clock_stop_instr || ce_reset) begin
			next_q.ge    = 1'b0;
			next_q.armed = 1'b0;
		end

		// Request flags: event set wins over write or acceptance clear
		if (take) begin
			next_q.req = q.req & ~grant;
		end
		if (reg_wr && reg_addr == REG_REQ) begin
			next_q.req = reg_wdata[N_SRC-1:0];
		end
		next_q.req = next_q.req | src_req;
		if (reg_wr && reg_addr == REG_EN) begin
			next_q.en = reg_wdata[N_SRC-1:0];
		end

		// Interrupt cycle sequencer
		if (q.state != ST_RUN) begin
			next_q.cnt = q.cnt + CNT_W'(1);
		end
		unique case (q.state)
			ST_RUN: begin
				if (take) begin
					next_q.accept  = 1'b1;
					next_q.busy    = 1'b1;
					next_q.cnt     = '0;
					next_q.vidx    = grant_idx;
					next_q.pc_save = pc_next;
					next_q.state   = ST_DEC_SP;
				end else if (instr_done && ret_any) begin
					next_q.pc_value = q.astk[q.sp];
					next_q.pc_load  = 1'b1;
					next_q.sp       = q.sp + SP_W'(1);
					if (irq_return_instr) begin
						next_q.sys      = q.isk[0];
						next_q.sys_load = 1'b1;
						next_q.isk[0]   = q.isk[1];
						next_q.isk[1]   = '0;
						if (q.depth != '0) begin
							next_q.depth = q.depth - DEPTH_W'(1);
						end
					end
				end
			end
			ST_DEC_SP: begin
				next_q.sp    = q.sp - SP_W'(1);
				next_q.state = ST_PUSH_PC;
			end
			ST_PUSH_PC: begin
				next_q.astk[q.sp] = q.pc_save;
				next_q.state      = ST_SAVE_SYS;
			end
			ST_SAVE_SYS: begin
				// Oldest level falls off; software must keep it itself
				next_q.isk[1] = q.isk[0];
				next_q.isk[0] = {window_in, bank_in, gp_reg_pointer_in,
				                 status_word_reg_in};
				if (q.depth != DEPTH_W'(ISK_LEVELS)) begin
					next_q.depth = q.depth + DEPTH_W'(1);
				end
				next_q.sys      = {window_in, {(SYS_W-WR_W){1'b0}}};
				next_q.sys_load = 1'b1;
				next_q.state    = ST_LOAD_VEC;
			end
			ST_LOAD_VEC: begin
				next_q.pc_value = PC_W'(q.vidx) + VEC_BASE;
				next_q.pc_load  = 1'b1;
				next_q.state    = ST_HOLD;
			end
			ST_HOLD: begin
				// Holds the sequencer for a full instruction time
				if (q.cnt == CNT_W'(IRQ_CYCLES - 1)) begin
					next_q.busy  = 1'b0;
					next_q.state = ST_RUN;
				end
			end
			default: next_q.state = ST_RUN;
		endcase

		// Chip-enable reset also clears the per-source flags
		if (ce_reset) begin
			next_q.req = src_req;
			next_q.en  = '0;
		end

		if (reg_rd) begin
			unique case (reg_addr)
				REG_REQ:  next_q.rdata = DATA_W'(q.req);
				REG_EN:   next_q.rdata = DATA_W'(q.en);
				REG_STAT: begin
					next_q.rdata[STAT_GE]  = q.ge;
					next_q.rdata[STAT_ARM] = q.armed;
					next_q.rdata[STAT_DEPTH_LSB +: DEPTH_W] = q.depth;
					next_q.rdata[STAT_SP_LSB +: SP_W]       = q.sp;
					next_q.rdata[STAT_BUSY] = q.busy;
				end
				default:  next_q.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			q       <= '0;
			q.state <= ST_RUN;
			q.sp    <= SP_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign reg_rdata            = q.rdata;
	assign global_irq_enable_ff = q.ge;
	assign irq_accept           = q.accept;
	assign irq_cycle_busy       = q.busy;
	assign pc_load              = q.pc_load;
	assign pc_value             = q.pc_value;
	assign sys_load             = q.sys_load;
	assign window_out           = q.sys[SYS_W-1 -: WR_W];
	assign bank_out             = q.sys[SYS_W-WR_W-1 -: BANK_W];
	assign gp_reg_pointer_out   = q.sys[PSW_W +: RP_W];
	assign status_word_reg_out  = q.sys[PSW_W-1:0];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_irq_steps;
		q.state == ST_DEC_SP ##1 q.state == ST_PUSH_PC ##1 q.state == ST_SAVE_SYS
		##1 q.state == ST_LOAD_VEC ##1 pc_load;
	endsequence

	property p_ge_gate;
		(instr_done && !q.ge && !q.armed) |=> !irq_accept;
	endproperty
	a_ge_gate: assert property (p_ge_gate) else $error("accepted while disabled");

	property p_ei_delay;
		$rose(q.ge) |-> $past(instr_done) && $past(q.armed);
	endproperty
	a_ei_delay: assert property (p_ei_delay) else $error("enable set too early");

	property p_di_now;
		mask_all_instr |=> !q.ge && !q.armed;
	endproperty
	a_di_now: assert property (p_di_now) else $error("mask-all did not clear");

	property p_accept_clear;
		take |=> !q.ge && irq_accept && irq_cycle_busy;
	endproperty
	a_accept_clear: assert property (p_accept_clear) else $error("enable kept");

	property p_stop_clear;
		(clock_stop_instr || ce_reset) |=> !q.ge;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop left enable");

	property p_req_set;
		(src_req != '0) |=> ((q.req & $past(src_req)) == $past(src_req));
	endproperty
	a_req_set: assert property (p_req_set) else $error("request event lost");

	property p_priority;
		take |-> $onehot(grant) && ((pend & ~grant) < grant);
	endproperty
	a_priority: assert property (p_priority) else $error("wrong source granted");

	property p_defer;
		(instr_done && instr_defer) |=> !irq_accept;
	endproperty
	a_defer: assert property (p_defer) else $error("accepted during defer");

	property p_irq_cycle;
		take |=> s_irq_steps ##0 (pc_value == PC_W'(q.vidx) + VEC_BASE);
	endproperty
	a_irq_cycle: assert property (p_irq_cycle) else $error("bad interrupt cycle");

	property p_busy_hold;
		take |=> irq_cycle_busy [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

	property p_window_keep;
		q.state == ST_SAVE_SYS |=> sys_load && window_out == $past(window_in)
		                           && bank_out == '0 && status_word_reg_out == '0;
	endproperty
	a_window_keep: assert property (p_window_keep) else $error("bad sys clear");

	property p_return;
		(instr_done && ret_any && q.state == ST_RUN && !take)
		|=> pc_load && q.sp == $past(q.sp) + SP_W'(1) && sys_load == $past(irq_return_instr);
	endproperty
	a_return: assert property (p_return) else $error("bad return");
endmodule
`default_nettype wire

// ===== testbench/via_seq_model.sv
// Purpose: Sequencer and system register model facing the acceptor
// Assumes: Bench picks the class of each instruction on op
// Notes:   Instruction time cut to SEQ_LEN cycles
`default_nettype none
module via_seq_model
	import via_pkg::*;
#(
	parameter int               SEQ_LEN  = 4,
	parameter logic [SYS_W-1:0] SYS_INIT = 20'hA3AB5
)(
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic [2:0]                op,
	input  wire logic                      irq_cycle_busy,
	input  wire logic                      pc_load,
	input  wire logic [via_pkg::PC_W-1:0]  pc_value,
	input  wire logic                      sys_load,
	input  wire logic [via_pkg::SYS_W-1:0] sys_out,
	output logic                           instr_done,
	output logic      [7:0]                cls,
	output logic      [via_pkg::PC_W-1:0]  pc_next,
	output logic      [via_pkg::SYS_W-1:0] sys
);
	logic [3:0] cnt;

	// No boundary while the interrupt cycle runs
	assign instr_done = (cnt == 4'(SEQ_LEN - 1)) && !irq_cycle_busy;
	// Mask-all stands its whole instruction, others only at the boundary
	assign cls = (instr_done ? (8'h01 << op) : 8'h00) | {5'h00, op == 3'h2, 2'h0};

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt     <= 4'h0;
			pc_next <= 14'h0100;
			sys     <= SYS_INIT;
		end else begin
			if (instr_done)
				cnt <= 4'h0;
			else if (cnt != 4'(SEQ_LEN - 1))
				cnt <= cnt + 4'h1;
			if (pc_load)
				pc_next <= pc_value;
			else if (instr_done)
				pc_next <= pc_next + 14'h0001;
			if (sys_load)
				sys <= sys_out;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: Self-checking bench of the vectored interrupt acceptor
// Assumes: Op 0 nop, 1 enable-all, 2 mask-all, 3 defer, 4..6 returns, 7 stop
// Notes:   Free-running sequencer model, so boundaries never wait on the bench
`default_nettype none
module testbench
	import via_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [SYS_W-1:0] SYS0 = 20'hA3AB5;
	localparam logic [SYS_W-1:0] SYSC = {SYS0[19:16], 16'h0000};
	logic                    mclk, rst_n, ce_reset, reg_wr, reg_rd;
	logic [2:0]              op;
	logic [N_SRC-1:0]        src_req;
	logic [ADDR_W-1:0]       reg_addr;
	logic [DATA_W-1:0]       reg_wdata;
	logic [PC_W-1:0]         last_pc, ret_exp, r;
	logic [SYS_W-1:0]        s;
	wire logic               instr_done, ge, acc, busy, pc_load, sys_load;
	wire logic [7:0]         cls;
	wire logic [DATA_W-1:0]  reg_rdata;
	wire logic [PC_W-1:0]    pc_next, pc_value;
	wire logic [SYS_W-1:0]   sys, sys_out;
	int                      failures, tests_run, cycles, n_acc, a;

	via_core DUT (.mclk(mclk), .rst_n(rst_n), .ce_reset(ce_reset), .src_req(src_req),
		.instr_done(instr_done), .enable_all_instr(cls[1]), .mask_all_instr(cls[2]),
		.clock_stop_instr(cls[7]), .instr_defer(cls[3]), .irq_return_instr(cls[4]),
		.subroutine_exit(cls[5]), .skip_subroutine_exit(cls[6]), .pc_next(pc_next),
		.window_in(sys[19:16]), .bank_in(sys[15:12]), .gp_reg_pointer_in(sys[11:5]),
		.status_word_reg_in(sys[4:0]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_enable_ff(ge),
		.irq_accept(acc), .irq_cycle_busy(busy), .pc_load(pc_load), .pc_value(pc_value),
		.sys_load(sys_load), .window_out(sys_out[19:16]), .bank_out(sys_out[15:12]),
		.gp_reg_pointer_out(sys_out[11:5]), .status_word_reg_out(sys_out[4:0]));

	via_seq_model #(.SEQ_LEN(4), .SYS_INIT(SYS0)) seq (.mclk(mclk), .rst_n(rst_n), .op(op),
		.irq_cycle_busy(busy), .pc_load(pc_load), .pc_value(pc_value), .sys_load(sys_load),
		.sys_out(sys_out), .instr_done(instr_done), .cls(cls), .pc_next(pc_next), .sys(sys));

	always #12.5 mclk = ~mclk;

	// Pulses are read mid-cycle, clear of the edge that launches them
	always @(negedge mclk) begin
		if (pc_load)
			last_pc <= pc_value;
		if (acc)
			n_acc <= n_acc + 1;
	end

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			give_verdict;
		end
	end

	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		tests_run++;
		if (got !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, e);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// Gap edge, so back-to-back writes never assign the strobe twice
		@(posedge mclk);
	endtask

	task automatic rdchk(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		// Data stands only this cycle
		#1;
		chk(32'(reg_rdata), 32'(e));
		@(posedge mclk);
	endtask

	task automatic pulse(input logic [N_SRC-1:0] m);
		src_req <= m;
		@(posedge mclk);
		src_req <= '0;
	endtask

	// Runs until the next boundary, keeping the address that would be pushed
	task automatic ins(input logic [2:0] o);
		int n;
		n = 0;
		op <= o;
		do begin
			@(negedge mclk);
			n++;
		end while (instr_done !== 1'b1 && n < 400);
		if (instr_done !== 1'b1)
			failures++;
		ret_exp = pc_next;
		@(posedge mclk);
		#1;
	endtask

	task automatic back(input logic [2:0] o, input logic [SYS_W-1:0] e);
		ins(o);
		ins(3'h0);
		chk(32'(last_pc), 32'(r));
		chk(32'(sys), 32'(e));
	endtask

	task automatic take;
		ins(3'h1);
		ins(3'h0);
		r = ret_exp;
		s = sys;
		ins(3'h0);
	endtask

	initial begin
		{mclk, rst_n, ce_reset, reg_wr, reg_rd, op, src_req, reg_addr, reg_wdata} = '0;
		{failures, tests_run} = '0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		wr(2'h3, 16'hFFFF);
		wr(REG_STAT, 16'hFFFF);
		rdchk(REG_REQ, 16'h0000);
		rdchk(REG_EN, 16'h0000);
		rdchk(REG_STAT, 16'h0000);
		rdchk(2'h3, 16'h0000);
		pulse(10'h020);
		rdchk(REG_REQ, 16'h0020);
		wr(REG_EN, 16'h03FF);
		ins(3'h0);
		ins(3'h0);
		chk(32'(n_acc), 0);
		op <= 3'h1;
		pulse(10'h100);
		ins(3'h1);
		chk(32'(ge), 0);
		ins(3'h0);
		r = ret_exp;
		s = sys;
		ins(3'h0);
		chk(32'(n_acc), 1);
		chk(32'(ge), 0);
		chk(32'(last_pc), 32'h9);
		chk(32'(sys), 32'(SYSC));
		rdchk(REG_REQ, 16'h0020);
		back(3'h4, s);
		wr(REG_REQ, 16'h03FF);
		for (int i = 9; i >= 0; i--) begin
			take;
			chk(32'(last_pc), 32'(i + 1));
			back(3'(4 + i % 3), (i % 3 == 0) ? s : SYSC);
		end
		rdchk(REG_REQ, 16'h0000);
		wr(REG_REQ, 16'h0300);
		wr(REG_EN, 16'h0100);
		take;
		chk(32'(last_pc), 32'h9);
		back(3'h5, SYSC);
		wr(REG_EN, 16'h0001);
		ins(3'h1);
		ins(3'h0);
		chk(32'(ge), 1);
		ins(3'h1);
		ins(3'h0);
		chk(32'(ge), 1);
		a = n_acc;
		pulse(10'h001);
		ins(3'h3);
		repeat (2) @(posedge mclk);
		chk(32'(n_acc), 32'(a));
		ins(3'h0);
		r = ret_exp;
		ins(3'h0);
		chk(32'(n_acc), 32'(a + 1));
		chk(32'(last_pc), 32'h1);
		back(3'h6, SYSC);
		ins(3'h1);
		ins(3'h0);
		chk(32'(ge), 1);
		op <= 3'h2;
		repeat (2) @(posedge mclk);
		#1;
		chk(32'(ge), 0);
		ins(3'h2);
		chk(32'(ge), 0);
		ins(3'h1);
		ins(3'h0);
		ins(3'h7);
		chk(32'(ge), 0);
		ins(3'h1);
		ins(3'h0);
		chk(32'(ge), 1);
		ce_reset <= 1'b1;
		@(posedge mclk);
		ce_reset <= 1'b0;
		#1;
		chk(32'(ge), 0);
		rdchk(REG_EN, 16'h0000);
		give_verdict;
	end
endmodule
`default_nettype wire
